/* hw/tcc_cfg.svh */
// Register offsets, field positions, reset values and widths for the
// timer channel clock and trigger block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_ADDR_W 8
`define TCC_OFF_CMD 8'h00
`define TCC_OFF_MODE 8'h04
`define TCC_OFF_STATUS 8'h08
`define TCC_OFF_COUNT 8'h0c
`define TCC_OFF_CMPC 8'h10
`define TCC_OFF_CAPB 8'h14

`define TCC_CMD_CLK_ON 0
`define TCC_CMD_CLK_OFF 1
`define TCC_CMD_SOFT_TRIG 2

`define TCC_MODE_WAVE 15
`define TCC_MODE_B_DIS 7
`define TCC_MODE_B_HALT 6
`define TCC_MODE_C_DIS 7
`define TCC_MODE_C_HALT 6
`define TCC_MODE_EXT_EN 10
`define TCC_MODE_EXT_ON_B 11
`define TCC_MODE_SYNC_EN 12
`define TCC_MODE_CLKSEL 0

`define TCC_ST_CLK_EN 16
`define TCC_ST_CPC 4
`define TCC_ST_LDRB 6
`define TCC_ST_LINE_A 17
`define TCC_ST_LINE_B 18
`define TCC_ST_EXT_CLK 19

`define TCC_MODE_RST 32'h0000_0000
`define TCC_CMPC_RST 16'hffff

`endif

/* hw/tcc_pkg.sv */
// Types shared by the timer channel clock and trigger block.
// Assumes the constants header is included by the files that need numbers.
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_CLK_SYS = 2'b00,
		TCC_CLK_DIV4 = 2'b01,
		TCC_CLK_EXT = 2'b10,
		TCC_CLK_DIV16 = 2'b11
	} tcc_clksel_e;

	typedef struct packed {
		logic wave;
		logic b_dis;
		logic b_halt;
		logic c_dis;
		logic c_halt;
		logic ext_en;
		logic ext_on_b;
		logic sync_en;
		tcc_clksel_e clksel;
	} tcc_mode_s;

	typedef struct packed {
		logic line_a_out;
		logic line_a_oe;
		logic line_b_out;
		logic line_b_oe;
	} tcc_io_s;
endpackage

/* hw/tcc_sync.sv */
// Two-flop synchroniser with edge output on the second stage.
// Assumes an asynchronous pin input and the system clock domain.
`timescale 1ns/1ns
module tcc_sync (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign o_level = sync_reg;
	assign o_rise = sync_reg & ~last_reg;
endmodule // tcc_sync

/* hw/tcc_channel.sv */
// One timer channel: clock enable, start and stop, capture or waveform
// mode, triggers and counter, behind an APB slave.
// Assumes one system clock; pins and the external clock come in async.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`include "tcc_cfg.svh"
module tcc_channel #(
	parameter int CNT_W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`TCC_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_sync_trig,
	input wire logic i_ext_clk,
	input wire logic i_line_a_in,
	input wire logic i_line_b_in,
	output logic o_line_a_out,
	output logic o_line_a_oe,
	output logic o_line_b_out,
	output logic o_line_b_oe
);
	typedef struct packed {
		tcc_pkg::tcc_mode_s mode;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] cmp_c;
		logic [CNT_W-1:0] cap_b;
		logic clk_en;
		logic started;
		logic trig_pend;
		logic cpc_flag;
		logic ldrb_flag;
		logic [3:0] prescale;
		tcc_pkg::tcc_io_s io;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tcc_state_s;

	tcc_state_s st_reg;
	tcc_state_s st_next;

	logic ext_clk_lvl;
	logic ext_clk_rise;
	logic a_lvl;
	logic a_rise;
	logic b_lvl;
	logic b_rise;

	tcc_sync u_sync_clk (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async(i_ext_clk),
		.o_level(ext_clk_lvl),
		.o_rise(ext_clk_rise)
	);
	tcc_sync u_sync_a (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async(i_line_a_in),
		.o_level(a_lvl),
		.o_rise(a_rise)
	);
	tcc_sync u_sync_b (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async(i_line_b_in),
		.o_level(b_lvl),
		.o_rise(b_rise)
	);

	function automatic logic [31:0] tcc_widen(input logic [CNT_W-1:0] v);
		logic [31:0] r;
		r = '0;
		r[CNT_W-1:0] = v;
		return r;
	endfunction

	function automatic logic tcc_hit(input logic [`TCC_ADDR_W-1:0] a,
		input logic [`TCC_ADDR_W-1:0] off);
		return a == off;
	endfunction

	logic acc;
	logic wr;
	logic rd;
	logic cmd_on;
	logic cmd_off;
	logic cmd_soft_trigger_cmd;
	logic tick;
	logic ext_trig;
	logic any_trig;
	logic b_load;
	logic c_match;
	logic mapped;
	logic [31:0] rdata;

	always_comb begin
		st_next = st_reg;
		acc = i_psel & i_penable & ~st_reg.pready;
		wr = acc & i_pwrite;
		rd = acc & ~i_pwrite;
		mapped = tcc_hit(i_paddr, `TCC_OFF_CMD) |
			tcc_hit(i_paddr, `TCC_OFF_MODE) |
			tcc_hit(i_paddr, `TCC_OFF_STATUS) |
			tcc_hit(i_paddr, `TCC_OFF_COUNT) |
			tcc_hit(i_paddr, `TCC_OFF_CMPC) |
			tcc_hit(i_paddr, `TCC_OFF_CAPB);
		// Commands exist only as decode of the write itself
		cmd_on = wr & tcc_hit(i_paddr, `TCC_OFF_CMD) &
			i_pwdata[`TCC_CMD_CLK_ON];
		cmd_off = wr & tcc_hit(i_paddr, `TCC_OFF_CMD) &
			i_pwdata[`TCC_CMD_CLK_OFF];
		cmd_soft_trigger_cmd = wr & tcc_hit(i_paddr, `TCC_OFF_CMD) &
			i_pwdata[`TCC_CMD_SOFT_TRIG];

		// Active edge of the selected counting clock
		unique case (st_reg.mode.clksel)
			tcc_pkg::TCC_CLK_SYS: tick = 1'b1;
			tcc_pkg::TCC_CLK_DIV4: tick = st_reg.prescale[1:0] == 2'h3;
			tcc_pkg::TCC_CLK_EXT: tick = ext_clk_rise;
			tcc_pkg::TCC_CLK_DIV16: tick = st_reg.prescale == 4'hf;
		endcase
		st_next.prescale = st_reg.prescale + 4'h1;

		// One external trigger per mode: line B in waveform, line A or B
		// in capture
		ext_trig = st_reg.mode.ext_en & (st_reg.mode.ext_on_b ? b_rise :
			(st_reg.mode.wave ? 1'b0 : a_rise));
		// Capture B loads on a rising edge of line B in capture mode, except in a cycle where an external trigger fires
		b_load = ~st_reg.mode.wave & b_rise & ~ext_trig;
		c_match = st_reg.mode.wave & st_reg.started & st_reg.clk_en &
			tick & (st_reg.count == st_reg.cmp_c);
		any_trig = cmd_soft_trigger_cmd | (st_reg.mode.sync_en & i_sync_trig) |
			ext_trig | (c_match & st_reg.mode.wave);

		if (any_trig)
			st_next.trig_pend = 1'b1;

		if (b_load) begin
			st_next.cap_b = st_reg.count;
			st_next.ldrb_flag = 1'b1;
		end
		if (c_match)
			st_next.cpc_flag = 1'b1;

		// Counting, start and stop only matter while enabled
		if (st_reg.clk_en && tick) begin
			if (st_reg.trig_pend || any_trig) begin
				st_next.count = '0;
				st_next.started = 1'b1;
				st_next.trig_pend = 1'b0;
			end else if (st_reg.started) begin
				st_next.count = st_reg.count + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
		if (st_reg.clk_en && ((b_load && st_reg.mode.b_halt) ||
			(c_match && st_reg.mode.c_halt)))
			st_next.started = 1'b0;
		if ((b_load && st_reg.mode.b_dis) || (c_match && st_reg.mode.c_dis))
			st_next.clk_en = 1'b0;
		if (cmd_off)
			st_next.clk_en = 1'b0;
		// Enable wins when both commands arrive together
		if (cmd_on)
			st_next.clk_en = 1'b1;
		if (!st_next.clk_en)
			st_next.trig_pend = 1'b0;

		// Pin direction follows the mode
		if (st_reg.mode.wave) begin
			st_next.io.line_a_oe = 1'b1;
			st_next.io.line_a_out = st_reg.started &
				(st_reg.count < st_reg.cmp_c);
			st_next.io.line_b_oe = ~(st_reg.mode.ext_en &
				st_reg.mode.ext_on_b);
			st_next.io.line_b_out = st_reg.started;
		end else begin
			st_next.io = '0;
		end

		rdata = 32'h0000_0000;
		unique case (1'b1)
			tcc_hit(i_paddr, `TCC_OFF_MODE): begin
				rdata[`TCC_MODE_WAVE] = st_reg.mode.wave;
				rdata[`TCC_MODE_EXT_EN] = st_reg.mode.ext_en;
				rdata[`TCC_MODE_EXT_ON_B] = st_reg.mode.ext_on_b;
				rdata[`TCC_MODE_SYNC_EN] = st_reg.mode.sync_en;
				rdata[`TCC_MODE_CLKSEL +: 2] = st_reg.mode.clksel;
				rdata[`TCC_MODE_B_DIS] = st_reg.mode.wave ?
					st_reg.mode.c_dis : st_reg.mode.b_dis;
				rdata[`TCC_MODE_B_HALT] = st_reg.mode.wave ?
					st_reg.mode.c_halt : st_reg.mode.b_halt;
			end
			tcc_hit(i_paddr, `TCC_OFF_STATUS): begin
				rdata[`TCC_ST_CLK_EN] = st_reg.clk_en;
				rdata[`TCC_ST_CPC] = st_reg.cpc_flag;
				rdata[`TCC_ST_LDRB] = st_reg.ldrb_flag;
				rdata[`TCC_ST_LINE_A] = a_lvl;
				rdata[`TCC_ST_LINE_B] = b_lvl;
				rdata[`TCC_ST_EXT_CLK] = ext_clk_lvl;
			end
			tcc_hit(i_paddr, `TCC_OFF_COUNT): rdata = tcc_widen(st_reg.count);
			tcc_hit(i_paddr, `TCC_OFF_CMPC): rdata = tcc_widen(st_reg.cmp_c);
			tcc_hit(i_paddr, `TCC_OFF_CAPB): rdata = tcc_widen(st_reg.cap_b);
			default: rdata = 32'h0000_0000;
		endcase

		// Status event flags clear on read; a same-cycle event wins
		if (rd && tcc_hit(i_paddr, `TCC_OFF_STATUS)) begin
			st_next.cpc_flag = c_match;
			st_next.ldrb_flag = b_load;
		end

		if (wr && tcc_hit(i_paddr, `TCC_OFF_MODE)) begin
			st_next.mode.wave = i_pwdata[`TCC_MODE_WAVE];
			st_next.mode.ext_en = i_pwdata[`TCC_MODE_EXT_EN];
			st_next.mode.ext_on_b = i_pwdata[`TCC_MODE_EXT_ON_B];
			st_next.mode.sync_en = i_pwdata[`TCC_MODE_SYNC_EN];
			st_next.mode.clksel = tcc_pkg::tcc_clksel_e'(
				i_pwdata[`TCC_MODE_CLKSEL +: 2]);
			// Same bit positions carry B or C controls by mode
			if (i_pwdata[`TCC_MODE_WAVE]) begin
				st_next.mode.c_dis = i_pwdata[`TCC_MODE_C_DIS];
				st_next.mode.c_halt = i_pwdata[`TCC_MODE_C_HALT];
				st_next.mode.b_dis = 1'b0;
				st_next.mode.b_halt = 1'b0;
			end else begin
				st_next.mode.b_dis = i_pwdata[`TCC_MODE_B_DIS];
				st_next.mode.b_halt = i_pwdata[`TCC_MODE_B_HALT];
				st_next.mode.c_dis = 1'b0;
				st_next.mode.c_halt = 1'b0;
			end
		end
		if (wr && tcc_hit(i_paddr, `TCC_OFF_CMPC))
			st_next.cmp_c = i_pwdata[CNT_W-1:0];

		// One wait state: answer the cycle after the access phase starts
		st_next.pready = acc;
		st_next.pslverr = acc & ~mapped;
		st_next.prdata = rd ? rdata : 32'h0000_0000;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			st_reg <= '0;
			st_reg.cmp_c <= CNT_W'(`TCC_CMPC_RST);
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_prdata = st_reg.prdata;
	assign o_pready = st_reg.pready;
	assign o_pslverr = st_reg.pslverr;
	assign o_line_a_out = st_reg.io.line_a_out;
	assign o_line_a_oe = st_reg.io.line_a_oe;
	assign o_line_b_out = st_reg.io.line_b_out;
	assign o_line_b_oe = st_reg.io.line_b_oe;
endmodule // tcc_channel

/* dv/tcc_channel_checker.sv */
// Assertions on the APB answer and pin directions of the timer channel.
// Assumes it is bound into tcc_channel and sees only its ports.
`timescale 1ns/1ns
`include "tcc_cfg.svh"
module tcc_channel_checker #(
	parameter int CNT_W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`TCC_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_line_a_oe,
	input wire logic o_line_b_oe
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	a_ready_follows: assert property (
		i_psel && i_penable && !o_pready |=> o_pready)
		else $error("access got no ready one cycle later");
	a_ready_single: assert property (
		o_pready |=> !o_pready) else $error("ready stood two cycles");
	a_ready_cause: assert property (
		o_pready |-> $past(i_psel && i_penable))
		else $error("ready without an access");
	a_err_unmapped: assert property (
		o_pready && !(i_paddr inside {`TCC_OFF_CMD, `TCC_OFF_MODE,
		`TCC_OFF_STATUS, `TCC_OFF_COUNT, `TCC_OFF_CMPC, `TCC_OFF_CAPB})
		|-> o_pslverr) else $error("unmapped access not refused");
	a_ok_mapped: assert property (
		o_pready && (i_paddr inside {`TCC_OFF_CMD, `TCC_OFF_MODE,
		`TCC_OFF_STATUS, `TCC_OFF_COUNT, `TCC_OFF_CMPC, `TCC_OFF_CAPB})
		|-> !o_pslverr) else $error("mapped access refused");
	a_err_with_ready: assert property (
		o_pslverr |-> o_pready) else $error("error without ready");
	a_cmd_reads_zero: assert property (
		o_pready && !i_pwrite && i_paddr == `TCC_OFF_CMD
		|-> o_prdata == 32'h0) else $error("command word read nonzero");
	a_rdata_idle: assert property (
		!o_pready |-> o_prdata == 32'h0) else $error("read data outside ready");
	a_b_needs_a: assert property (
		o_line_b_oe |-> o_line_a_oe) else $error("line B driven without A");
	a_reset_quiet: assert property (
		$rose(i_rst_n) |-> !o_pready && !o_line_a_oe && !o_line_b_oe)
		else $error("outputs active after reset");
endmodule // tcc_channel_checker

bind tcc_channel tcc_channel_checker #(.CNT_W(CNT_W)) u_chk (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_line_a_oe(o_line_a_oe), .o_line_b_oe(o_line_b_oe));

/* dv/tcc_pins.sv */
// Model of the parts wired to the channel's pins and clock input.
// Assumes the bench asks for line B pulses and starts the clock.
`timescale 1ns/1ns
module tcc_pins (
	input wire logic i_clk_sys,
	input wire logic i_b_req,
	input wire logic i_ext_run,
	output logic o_line_a,
	output logic o_line_b,
	output logic o_ext_clk
);
	logic [2:0] div = 3'h0;
	logic [2:0] hold = 3'h0;
	// Clock stands still when stopped, so no edge is counted then
	always @(posedge i_clk_sys) begin
		if (i_ext_run)
			div <= div + 3'h1;
		hold <= i_b_req ? 3'h6 : hold - {2'h0, hold != 3'h0};
	end
	assign o_ext_clk = div[1];
	assign o_line_a = div[2];
	assign o_line_b = hold != 3'h0;
endmodule // tcc_pins

/* dv/tb_timer_channel_clock_trigger.sv */
// Self-checking bench for the timer channel over APB.
// Assumes one wait state per access and the pin model beside it.
`timescale 1ns/1ns
module tb_timer_channel_clock_trigger;
	typedef struct {
		logic w;
		logic [7:0] a;
		logic [31:0] d, m, x;
		logic ex;
	} tcc_row_s;
	logic clk, rst_n, psel, pen, pwr, sync, run, breq, e;
	logic rdy, err, la, lb, ek, ao, aoe, bo, boe;
	logic [7:0] pa;
	logic [31:0] pwd, prd, r, q;
	int n_mismatch, n_compared;
	tcc_row_s rows[16] = '{
		'{1'h0,8'h08,32'h0,32'h1_0000,32'h0,1'h0},
		'{1'h1,8'h00,32'h1,32'h0,32'h0,1'h0},
		'{1'h0,8'h08,32'h0,32'h1_0000,32'h1_0000,1'h0},
		'{1'h1,8'h00,32'h2,32'h0,32'h0,1'h0},
		'{1'h0,8'h08,32'h0,32'h1_0000,32'h0,1'h0},
		'{1'h1,8'h00,32'h4,32'h0,32'h0,1'h0},
		'{1'h0,8'h0c,32'h0,32'hffff_ffff,32'h0,1'h0},
		'{1'h0,8'h00,32'h0,32'hffff_ffff,32'h0,1'h0},
		'{1'h1,8'h10,32'h5,32'h0,32'h0,1'h0},
		'{1'h0,8'h10,32'h0,32'hffff,32'h5,1'h0},
		'{1'h1,8'h18,32'h1,32'h0,32'h0,1'h1},
		'{1'h0,8'h40,32'h0,32'hffff_ffff,32'h0,1'h1},
		'{1'h1,8'h00,32'h3,32'h0,32'h0,1'h0},
		'{1'h0,8'h08,32'h0,32'h1_0000,32'h1_0000,1'h0},
		'{1'h1,8'h00,32'h0,32'h0,32'h0,1'h0},
		'{1'h0,8'h08,32'h0,32'h1_0000,32'h1_0000,1'h0}
	};
	tcc_channel u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
		.o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_sync_trig(sync),
		.i_ext_clk(ek), .i_line_a_in(la), .i_line_b_in(lb), .o_line_a_out(ao),
		.o_line_a_oe(aoe), .o_line_b_out(bo), .o_line_b_oe(boe));
	tcc_pins u_pins (.i_clk_sys(clk), .i_b_req(breq), .i_ext_run(run),
		.o_line_a(la), .o_line_b(lb), .o_ext_clk(ek));
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		q = prd;
		e = err;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task two(input int n);
		apb(1'h0, 8'h0c, 32'h0);
		r = q;
		repeat (n) @(posedge clk);
		apb(1'h0, 8'h0c, 32'h0);
	endtask
	task arm(input logic [31:0] m);
		apb(1'h1, 8'h04, m);
		apb(1'h1, 8'h00, 32'h1);
		apb(1'h1, 8'h00, 32'h4);
	endtask
	task pb;
		breq <= 1'h1;
		@(posedge clk);
		breq <= 1'h0;
	endtask
	task tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		$display("[ERR] %0t watchdog expired", $time);
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		{rst_n, psel, pen, pwr, sync, run, breq} = 7'h0;
		pa = 8'h0;
		pwd = 32'h0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk(q & rows[i].m, rows[i].x);
			chk({31'h0, e}, {31'h0, rows[i].ex});
		end
		arm(32'h0);
		two(4);
		chk({31'h0, q > r}, 32'h1);
		apb(1'h1, 8'h00, 32'h2);
		two(4);
		chk(q, r);
		apb(1'h1, 8'h00, 32'h4);
		apb(1'h0, 8'h0c, 32'h0);
		chk(q, r);
		apb(1'h1, 8'h04, 32'h8000);
		repeat (2) @(posedge clk);
		chk({30'h0, aoe, boe}, 32'h3);
		apb(1'h0, 8'h04, 32'h0);
		chk(q, 32'h8000);
		apb(1'h1, 8'h04, 32'h8c00);
		repeat (2) @(posedge clk);
		chk({30'h0, aoe, boe}, 32'h2);
		apb(1'h1, 8'h04, 32'h0);
		repeat (2) @(posedge clk);
		chk({30'h0, aoe, boe}, 32'h0);
		apb(1'h1, 8'h10, 32'h3);
		arm(32'h8080);
		repeat (20) @(posedge clk);
		apb(1'h0, 8'h08, 32'h0);
		chk(q & 32'h1_0010, 32'h10);
		arm(32'h8040);
		repeat (20) @(posedge clk);
		apb(1'h0, 8'h08, 32'h0);
		chk(q & 32'h1_0000, 32'h1_0000);
		two(4);
		chk(q, r);
		arm(32'h0080);
		pb;
		repeat (12) @(posedge clk);
		apb(1'h0, 8'h08, 32'h0);
		chk(q & 32'h1_0040, 32'h40);
		arm(32'h0040);
		pb;
		repeat (12) @(posedge clk);
		two(4);
		chk(q, r);
		run <= 1'h1;
		apb(1'h1, 8'h04, 32'h1002);
		apb(1'h1, 8'h00, 32'h1);
		sync <= 1'h1;
		@(posedge clk);
		sync <= 1'h0;
		repeat (30) @(posedge clk);
		two(12);
		chk({31'h0, q > r}, 32'h1);
		run <= 1'h0;
		repeat (10) @(posedge clk);
		two(12);
		chk(q, r);
		// External clock stands still, so the trigger stays pending
		apb(1'h1, 8'h00, 32'h4);
		apb(1'h0, 8'h0c, 32'h0);
		chk(q, r);
		// Eight steps of the pin divider give exactly two clock edges
		run <= 1'h1;
		repeat (8) @(posedge clk);
		run <= 1'h0;
		repeat (6) @(posedge clk);
		apb(1'h0, 8'h0c, 32'h0);
		chk(q, 32'h1);
		apb(1'h1, 8'h04, 32'h0440);
		pb;
		repeat (12) @(posedge clk);
		two(4);
		chk(q, r);
		run <= 1'h1;
		repeat (10) @(posedge clk);
		run <= 1'h0;
		repeat (4) @(posedge clk);
		two(4);
		chk({31'h0, q > r}, 32'h1);
		// Samples lie 64 and 16 cycles apart
		apb(1'h1, 8'h04, 32'h0003);
		two(60);
		chk(q - r, 32'h4);
		apb(1'h1, 8'h04, 32'h0001);
		two(12);
		chk(q - r, 32'h4);
		apb(1'h1, 8'h10, 32'h40);
		apb(1'h1, 8'h04, 32'h8040);
		apb(1'h1, 8'h00, 32'h4);
		repeat (2) @(posedge clk);
		chk({30'h0, ao, bo}, 32'h3);
		repeat (80) @(posedge clk);
		chk({30'h0, ao, bo}, 32'h0);
		apb(1'h1, 8'h04, 32'h8000);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		apb(1'h0, 8'h08, 32'h0);
		chk(q & 32'h1_0000, 32'h0);
		chk({30'h0, aoe, boe}, 32'h0);
		tally_and_finish;
	end
endmodule // tb_timer_channel_clock_trigger
